//--- sbr_pkg.sv
/*
 * sbr_pkg: shared constants and carrier types for the secure-boot reset and isolation control.
 * assumes one 100 MHz clock and no register bus.
 */
`default_nettype none
package sbr_pkg;
	localparam int          CLK_MHZ            = 100;
	localparam int          HB_TIMEOUT_US      = 1000;
	localparam int          HB_TIMEOUT_CYC     = HB_TIMEOUT_US * CLK_MHZ;
	localparam int          TRISTATE_SETTLE_NS = 20;
	localparam int          TRISTATE_CYC       = (TRISTATE_SETTLE_NS + 9) / 10;
	localparam logic [3:0]  ISO_RESET          = 4'hf;
	localparam logic        RESET_OUT_RESET    = 1'h0;
	localparam int          SYNC_STAGES        = 2;

	typedef enum logic [2:0] {
		SBR_ST_AUTH     = 3'h0,
		SBR_ST_TRISTATE = 3'h1,
		SBR_ST_RELEASE  = 3'h2,
		SBR_ST_RUN      = 3'h3,
		SBR_ST_FATAL    = 3'h4
	} sbr_state_t;

	// events detected on the monitored inputs
	typedef struct packed {
		logic system_reset;
		logic external_reset;
		logic primary_unexpected;
		logic secondary_unexpected;
		logic watchdog;
	} sbr_events_t;

	// result handed over by the authentication engine
	typedef struct packed {
		logic       done;
		logic       primary_ok;
		logic       secondary_ok;
		logic [3:0] flash_pass;
	} sbr_auth_t;
endpackage : sbr_pkg
`default_nettype wire

//--- sbr_edge_sync.sv
/*
 * sbr_edge_sync: two-flop synchroniser with rise and fall pulses.
 * assumes an input asynchronous to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module sbr_edge_sync #(
	parameter logic INIT = 1'h1
) (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic async_in,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= INIT;
			sync_q <= INIT;
			prev_q <= INIT;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise  = sync_q & ~prev_q;
	assign fall  = ~sync_q & prev_q;
endmodule : sbr_edge_sync
`default_nettype wire

//--- sbr_heartbeat_mon.sv
/*
 * sbr_heartbeat_mon: flags a stopped host heartbeat after a timeout.
 * assumes a synchronised heartbeat level and an enable that is high in runtime.
 */
`timescale 1ns/1ps
`default_nettype none
module sbr_heartbeat_mon #(
	parameter int TIMEOUT_CYC = sbr_pkg::HB_TIMEOUT_CYC
) (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic enable,
	input  wire logic hb_level,
	output logic      stalled
);
	localparam int CW = $clog2(TIMEOUT_CYC + 1);
	logic [CW-1:0] cnt_q;
	logic          prev_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q   <= '0;
			prev_q  <= 1'h1;
			stalled <= 1'h0;
		end else begin
			prev_q  <= hb_level;
			stalled <= 1'h0;
			if (!enable || (hb_level != prev_q)) begin
				cnt_q <= '0;
			end else if (cnt_q == CW'(TIMEOUT_CYC - 1)) begin
				cnt_q   <= '0;
				stalled <= 1'h1;
			end else begin
				cnt_q <= cnt_q + CW'(1);
			end
		end
	end
endmodule : sbr_heartbeat_mon
`default_nettype wire

//--- sbr_reset_ctrl.sv
/*
 * sbr_reset_ctrl: holds hosts in reset, isolates flash, watches reset sources, signals status.
 * assumes an authentication engine that starts on the auth_start pulse and returns sbr_auth_t.
 */
// Notes on behaviour
// - primary reset stays low from power-up until primary images authenticate
// - secondary reset stays low until secondary images authenticate
// - secondary reset never high while primary reset is low
// - runtime reset output mirrors primary reset during authentication
// - falling reset-detect counts as unexpected reset only while primary reset high
// - both watchdog inputs are rising-edge events
// - fatal-error low when primary reset cannot be released
// - remote-access high whenever fatal-error is low
// - four isolation outputs, high cuts host from that flash
// - own shared flash port tristated before primary isolation goes low
// - falling system-reset detect resets host and re-authenticates everything, any time
// - falling external reset in runtime asserts runtime reset, re-authenticates primary
// - stopped heartbeat after release is handled as watchdog event
// - bypass input skips authentication when enabled and 1
// - two active-high auth LEDs and one active-low progress LED
// - each optional pin function gated by its own configuration bit, except the address strap, which is always sampled
// - alert output is only pulled low, never driven high
// - address strap sampled to select target address
// - secondary reset monitor detects resets not generated here
// - fatal, pending and complete status encodings on error, reset, isolation pins
`timescale 1ns/1ps
`default_nettype none
module sbr_reset_ctrl #(
	parameter int HB_TIMEOUT_CYC = sbr_pkg::HB_TIMEOUT_CYC
) (
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	input  wire logic          system_reset_detect_n,
	input  wire logic          primary_host_reset_detect_n,
	input  wire logic          external_reset_in_n,
	input  wire logic          primary_host_heartbeat_n,
	input  wire logic          secondary_host_reset_monitor_n,
	input  wire logic          host_watchdog_reset_a,
	input  wire logic          host_watchdog_reset_b,
	input  wire logic          auth_bypass,
	input  wire logic          target_address_strap,
	input  wire logic          cfg_secondary_en,
	input  wire logic          cfg_external_reset_en,
	input  wire logic          cfg_system_reset_en,
	input  wire logic          cfg_reset_detect_en,
	input  wire logic          cfg_heartbeat_en,
	input  wire logic          cfg_secondary_monitor_en,
	input  wire logic          cfg_watchdog_en,
	input  wire logic          cfg_bypass_en,
	input  wire logic          cfg_alert_en,
	input  wire sbr_pkg::sbr_auth_t auth_result,
	input  wire logic          fw_alert,
	output logic               auth_start,
	output logic               auth_primary_only,
	output logic               primary_host_reset_n,
	output logic               secondary_host_reset_n,
	output logic               runtime_host_reset_n,
	output logic               fatal_error_n,
	output logic               remote_access,
	output logic               primary_flash0_isolate,
	output logic               primary_flash1_isolate,
	output logic               secondary_flash0_isolate,
	output logic               secondary_flash1_isolate,
	output logic               shared_flash_port_oe,
	output logic               primary_auth_led,
	output logic               secondary_auth_led,
	output logic               boot_progress_led_n,
	output logic               host_alert_out,
	output logic               host_alert_oe,
	output logic               target_address_sel,
	output sbr_pkg::sbr_events_t events
);
	////////////////////////////////////////////////////////////////////////
	// input synchronisers
	logic sys_fall;
	logic det_fall;
	logic ext_fall;
	logic hb_lvl;
	logic mon_fall;
	logic wda_rise, wdb_rise;
	logic byp_lvl, strap_lvl;
	logic hb_stall;

	sbr_edge_sync #(.INIT(1'h1)) u_sys (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(system_reset_detect_n),
		.level(), .rise(), .fall(sys_fall));
	sbr_edge_sync #(.INIT(1'h0)) u_det (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(primary_host_reset_detect_n),
		.level(), .rise(), .fall(det_fall));
	sbr_edge_sync #(.INIT(1'h1)) u_ext (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(external_reset_in_n),
		.level(), .rise(), .fall(ext_fall));
	sbr_edge_sync #(.INIT(1'h1)) u_hb (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(primary_host_heartbeat_n),
		.level(hb_lvl), .rise(), .fall());
	sbr_edge_sync #(.INIT(1'h1)) u_mon (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(secondary_host_reset_monitor_n),
		.level(), .rise(), .fall(mon_fall));
	sbr_edge_sync #(.INIT(1'h0)) u_wda (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(host_watchdog_reset_a),
		.level(), .rise(wda_rise), .fall());
	sbr_edge_sync #(.INIT(1'h0)) u_wdb (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(host_watchdog_reset_b),
		.level(), .rise(wdb_rise), .fall());
	sbr_edge_sync #(.INIT(1'h0)) u_byp (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(auth_bypass),
		.level(byp_lvl), .rise(), .fall());
	sbr_edge_sync #(.INIT(1'h0)) u_strap (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(target_address_strap),
		.level(strap_lvl), .rise(), .fall());

	////////////////////////////////////////////////////////////////////////
	// event decode
	sbr_pkg::sbr_state_t state_q;
	logic                in_run;
	logic                pri_rst_q;
	logic                sec_rst_q;
	logic                ext_rst_q;
	logic                owned_sec_q;

	assign in_run = (state_q == sbr_pkg::SBR_ST_RUN);

	sbr_heartbeat_mon #(.TIMEOUT_CYC(HB_TIMEOUT_CYC)) u_hbmon (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.enable   (cfg_heartbeat_en & in_run & pri_rst_q),
		.hb_level (hb_lvl),
		.stalled  (hb_stall)
	);

	always_comb begin
		events.system_reset         = cfg_system_reset_en & sys_fall;
		events.external_reset       = cfg_external_reset_en & ext_fall & in_run;
		events.primary_unexpected   = cfg_reset_detect_en & det_fall & pri_rst_q;
		events.secondary_unexpected = cfg_secondary_monitor_en & mon_fall & ~owned_sec_q;
		events.watchdog             = in_run & ((cfg_watchdog_en & (wda_rise | wdb_rise)) | hb_stall);
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer
	logic [3:0]                       iso_q;
	logic [3:0]                       iso_d;
	logic                             primary_only_q;
	localparam int                    TRI_CW = $clog2(sbr_pkg::TRISTATE_CYC + 1);
	logic [TRI_CW-1:0]                tri_cnt_q;
	logic                             fatal_q;
	logic                             start_q;
	logic                             bypass;
	logic                             full_reauth;

	assign bypass      = cfg_bypass_en & byp_lvl;
	assign full_reauth = events.system_reset | events.primary_unexpected | events.watchdog;

	always_comb begin
		iso_d = ~auth_result.flash_pass;
		if (bypass) begin
			iso_d = 4'h0;
		end
		if (!cfg_secondary_en) begin
			iso_d[3:2] = 2'h3;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q        <= sbr_pkg::SBR_ST_AUTH;
			iso_q          <= sbr_pkg::ISO_RESET;
			pri_rst_q      <= sbr_pkg::RESET_OUT_RESET;
			sec_rst_q      <= sbr_pkg::RESET_OUT_RESET;
			ext_rst_q      <= sbr_pkg::RESET_OUT_RESET;
			fatal_q        <= 1'h0;
			start_q        <= 1'h1;
			primary_only_q <= 1'h0;
			tri_cnt_q      <= '0;
		end else begin
			start_q <= 1'h0;
			if (full_reauth) begin
				state_q        <= sbr_pkg::SBR_ST_AUTH;
				pri_rst_q      <= 1'h0;
				sec_rst_q      <= 1'h0;
				ext_rst_q      <= 1'h0;
				iso_q          <= sbr_pkg::ISO_RESET;
				fatal_q        <= 1'h0;
				start_q        <= 1'h1;
				primary_only_q <= 1'h0;
			end else if (events.external_reset) begin
				state_q        <= sbr_pkg::SBR_ST_AUTH;
				ext_rst_q      <= 1'h0;
				pri_rst_q      <= 1'h0;
				sec_rst_q      <= 1'h0;
				iso_q[1:0]     <= 2'h3;
				start_q        <= 1'h1;
				primary_only_q <= 1'h1;
			end else begin
				case (state_q)
					sbr_pkg::SBR_ST_AUTH: begin
						if (bypass || auth_result.done) begin
							if (!bypass && !auth_result.primary_ok) begin
								state_q <= sbr_pkg::SBR_ST_FATAL;
								fatal_q <= 1'h1;
							end else begin
								state_q   <= sbr_pkg::SBR_ST_TRISTATE;
								tri_cnt_q <= '0;
							end
						end
					end
					sbr_pkg::SBR_ST_TRISTATE: begin
						if (tri_cnt_q == TRI_CW'(sbr_pkg::TRISTATE_CYC - 1)) begin
							state_q <= sbr_pkg::SBR_ST_RELEASE;
							if (primary_only_q) begin
								iso_q[1:0] <= iso_d[1:0];
							end else begin
								iso_q <= iso_d;
							end
						end else begin
							tri_cnt_q <= tri_cnt_q + TRI_CW'(1);
						end
					end
					sbr_pkg::SBR_ST_RELEASE: begin
						state_q   <= sbr_pkg::SBR_ST_RUN;
						pri_rst_q <= 1'h1;
						ext_rst_q <= 1'h1;
					end
					sbr_pkg::SBR_ST_RUN: begin
						if (!sec_rst_q && cfg_secondary_en && pri_rst_q &&
						    (bypass || auth_result.secondary_ok)) begin
							sec_rst_q <= 1'h1;
						end
					end
					sbr_pkg::SBR_ST_FATAL: begin
						state_q <= sbr_pkg::SBR_ST_FATAL;
					end
					default: begin
						state_q <= sbr_pkg::SBR_ST_AUTH;
					end
				endcase
			end
		end
	end

	// track whether the secondary reset low came from here
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			owned_sec_q <= 1'h1;
		end else begin
			owned_sec_q <= ~sec_rst_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// strap capture, alert and leds
	logic strap_done_q;
	logic addr_q;
	logic [1:0] strap_wait_q;
	logic alert_q;
	logic pled_q, sled_q, prog_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strap_done_q <= 1'h0;
			strap_wait_q <= 2'h0;
			addr_q       <= 1'h0;
		end else if (!strap_done_q) begin
			strap_wait_q <= strap_wait_q + 2'h1;
			if (strap_wait_q == 2'h3) begin
				addr_q       <= strap_lvl;
				strap_done_q <= 1'h1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			alert_q <= 1'h0;
			pled_q  <= 1'h0;
			sled_q  <= 1'h0;
			prog_q  <= 1'h1;
		end else begin
			alert_q <= cfg_alert_en & fw_alert;
			pled_q  <= pri_rst_q;
			sled_q  <= sec_rst_q;
			prog_q  <= ~(in_run | fatal_q);
		end
	end

	assign host_alert_out     = 1'h0;
	assign host_alert_oe      = alert_q;
	assign target_address_sel = addr_q;
	assign primary_auth_led   = pled_q;
	assign secondary_auth_led = sled_q;
	assign boot_progress_led_n = prog_q;

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign auth_start               = start_q;
	assign auth_primary_only        = primary_only_q;
	assign primary_host_reset_n     = pri_rst_q;
	assign secondary_host_reset_n   = sec_rst_q & pri_rst_q;
	assign runtime_host_reset_n     = ext_rst_q;
	assign fatal_error_n            = ~fatal_q;
	assign remote_access            = fatal_q;
	assign primary_flash0_isolate   = iso_q[0];
	assign primary_flash1_isolate   = iso_q[1];
	assign secondary_flash0_isolate = iso_q[2];
	assign secondary_flash1_isolate = iso_q[3];
	assign shared_flash_port_oe     = (state_q == sbr_pkg::SBR_ST_AUTH) & ~pri_rst_q;
endmodule : sbr_reset_ctrl
`default_nettype wire

//--- sbr_checker.sv
/* sbr_checker: port checks on the reset control.
 * assumes it is bound to sbr_reset_ctrl. */
`timescale 1ns/1ps
`default_nettype none
module sbr_checker (
	input wire logic                 clk_sys,
	input wire logic                 rst_n,
	input wire logic                 cfg_secondary_en,
	input wire logic                 cfg_system_reset_en,
	input wire logic                 cfg_external_reset_en,
	input wire logic                 primary_host_reset_n,
	input wire logic                 secondary_host_reset_n,
	input wire logic                 runtime_host_reset_n,
	input wire logic                 fatal_error_n,
	input wire logic                 remote_access,
	input wire logic                 primary_flash0_isolate,
	input wire logic                 primary_flash1_isolate,
	input wire logic                 secondary_flash0_isolate,
	input wire logic                 secondary_flash1_isolate,
	input wire logic                 shared_flash_port_oe,
	input wire logic                 host_alert_out,
	input wire sbr_pkg::sbr_events_t events
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	a_sec_after_pri: assert property (secondary_host_reset_n |-> primary_host_reset_n)
		else $error("secondary out of reset first");
	a_rt_after_pri: assert property (runtime_host_reset_n |-> primary_host_reset_n)
		else $error("runtime reset released early");
	a_remote_fatal: assert property (remote_access == !fatal_error_n)
		else $error("remote access wrong");
	a_fatal_code: assert property (!fatal_error_n |-> !runtime_host_reset_n
		&& primary_flash0_isolate && primary_flash1_isolate)
		else $error("fatal encoding wrong");
	a_fatal_holds: assert property (!fatal_error_n |-> !primary_host_reset_n)
		else $error("host released in fatal");
	a_iso_tristate: assert property ($fell(primary_flash0_isolate) || $fell(primary_flash1_isolate)
		|-> !shared_flash_port_oe && !$past(shared_flash_port_oe))
		else $error("isolation dropped while driving");
	a_alert_low: assert property (host_alert_out == 1'h0)
		else $error("alert driven high");
	a_sec_cfg_off: assert property (!$past(cfg_secondary_en)
		|-> secondary_flash0_isolate && secondary_flash1_isolate)
		else $error("secondary isolation open");
	a_sys_reauth: assert property (events.system_reset && cfg_system_reset_en
		|-> ##[1:3] !primary_host_reset_n)
		else $error("system reset ignored");
	a_ext_runtime: assert property (events.external_reset && cfg_external_reset_en
		&& runtime_host_reset_n |-> ##[1:3] !runtime_host_reset_n)
		else $error("external reset ignored");
	a_unexp_gate: assert property (events.primary_unexpected |-> primary_host_reset_n)
		else $error("unexpected reset while held");
endmodule : sbr_checker
bind sbr_reset_ctrl sbr_checker chk_u (.clk_sys, .rst_n, .cfg_secondary_en, .cfg_system_reset_en,
	.cfg_external_reset_en, .primary_host_reset_n, .secondary_host_reset_n, .runtime_host_reset_n,
	.fatal_error_n, .remote_access, .primary_flash0_isolate, .primary_flash1_isolate,
	.secondary_flash0_isolate, .secondary_flash1_isolate, .shared_flash_port_oe,
	.host_alert_out, .events);
`default_nettype wire

//--- sbr_host_model.sv
/* sbr_host_model: primary host seen from the reset control.
 * assumes pull-down on reset-detect and pull-up on heartbeat. */
`timescale 1ns/1ps
`default_nettype none
module sbr_host_model (
	input  wire logic clk_sys,
	input  wire logic primary_host_reset_n,
	input  wire logic crash,
	input  wire logic hb_stop,
	output logic      reset_detect_n,
	output logic      heartbeat_n,
	output logic      flash_drive_oe
);
	logic [2:0] run_q = 3'h0;
	logic [1:0] hb_q  = 2'h0;
	always_ff @(posedge clk_sys) begin
		run_q <= primary_host_reset_n ? run_q + {2'h0, run_q != 3'h7} : 3'h0;
		hb_q  <= hb_q + 2'h1;
	end
	// pins float in reset, pulls give the level
	assign reset_detect_n = (run_q > 3'h2) && !crash;
	// shared flash pins driven only once out of reset
	assign flash_drive_oe = (run_q != 3'h0);
	assign heartbeat_n    = (run_q == 3'h0) || hb_stop || hb_q[1];
endmodule : sbr_host_model
`default_nettype wire

//--- testbench.sv
/* testbench: directed scenarios for sbr_reset_ctrl.
 * assumes a 100 MHz clock and the host model. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_sys = 1'h0, rst_n = 1'h0, cfg_on = 1'h1, fw_alert = 1'h0;
	logic system_reset_detect_n = 1'h1, external_reset_in_n = 1'h1;
	logic host_watchdog_reset_a = 1'h0, host_watchdog_reset_b = 1'h0;
	logic auth_bypass = 1'h0, target_address_strap = 1'h1, crash = 1'h0, hb_stop = 1'h0, sec_mon_n = 1'h1;
	sbr_pkg::sbr_auth_t auth_result = '0;
	logic primary_host_reset_detect_n, primary_host_heartbeat_n, auth_primary_only;
	logic primary_host_reset_n, secondary_host_reset_n, runtime_host_reset_n;
	logic fatal_error_n, remote_access, primary_auth_led, secondary_auth_led;
	logic primary_flash0_isolate, primary_flash1_isolate;
	logic secondary_flash0_isolate, secondary_flash1_isolate;
	logic host_alert_out, host_alert_oe, target_address_sel;
	logic auth_start, shared_flash_port_oe, boot_progress_led_n, flash_drive_oe;
	sbr_pkg::sbr_events_t events;
	int bad_count = 0, compares = 0, cycles = 0;
	always #5 clk_sys = !clk_sys;
	sbr_reset_ctrl #(.HB_TIMEOUT_CYC(16)) dut_u (.clk_sys, .rst_n, .system_reset_detect_n,
		.primary_host_reset_detect_n, .external_reset_in_n, .primary_host_heartbeat_n,
		.secondary_host_reset_monitor_n(sec_mon_n), .host_watchdog_reset_a, .host_watchdog_reset_b,
		.auth_bypass, .target_address_strap, .cfg_secondary_en(cfg_on),
		.cfg_external_reset_en(cfg_on), .cfg_system_reset_en(cfg_on), .cfg_reset_detect_en(cfg_on),
		.cfg_heartbeat_en(cfg_on), .cfg_secondary_monitor_en(cfg_on), .cfg_watchdog_en(cfg_on),
		.cfg_bypass_en(cfg_on), .cfg_alert_en(cfg_on), .auth_result, .fw_alert, .auth_start,
		.auth_primary_only, .primary_host_reset_n, .secondary_host_reset_n, .runtime_host_reset_n,
		.fatal_error_n, .remote_access, .primary_flash0_isolate, .primary_flash1_isolate,
		.secondary_flash0_isolate, .secondary_flash1_isolate, .shared_flash_port_oe,
		.primary_auth_led, .secondary_auth_led, .boot_progress_led_n, .host_alert_out,
		.host_alert_oe, .target_address_sel, .events);
	sbr_host_model host_u (.clk_sys, .primary_host_reset_n, .crash, .hb_stop,
		.reset_detect_n(primary_host_reset_detect_n), .heartbeat_n(primary_host_heartbeat_n),
		.flash_drive_oe);
	////////////////////////////////////////////////////////////////////////////////
	task wrap_up;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count = bad_count + 1;
			wrap_up();
		end
	end
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// wait for primary or runtime reset to reach a level
	task await_lvl(input bit use_rt, input logic e);
		int i;
		for (i = 0; i < 60 && (use_rt ? runtime_host_reset_n : primary_host_reset_n) !== e; i++) begin
			cyc(1);
		end
		chk({7'h0, use_rt ? runtime_host_reset_n : primary_host_reset_n}, {7'h0, e});
	endtask : await_lvl
	task grant(input logic ok, input logic [3:0] pass);
		auth_result = '{1'h1, ok, 1'h1, pass};
	endtask : grant
	task release_host;
		grant(1'h1, 4'hf);
		await_lvl(1'b0, 1'h1);
		auth_result.done = 1'h0;
	endtask : release_host
	////////////////////////////////////////////////////////////////////////////////
	task t_boot;
		cyc(20);
		chk({primary_host_reset_n, runtime_host_reset_n, secondary_host_reset_n}, 8'h0);
		chk({primary_flash1_isolate, primary_flash0_isolate, fatal_error_n}, 8'h7);
		chk({shared_flash_port_oe, flash_drive_oe, boot_progress_led_n}, 8'h5);
		fw_alert = 1'h1;
		grant(1'h1, 4'ha);
		await_lvl(1'b0, 1'h1);
		auth_result.done = 1'h0;
		cyc(3);
		chk({secondary_flash1_isolate, secondary_flash0_isolate, primary_flash1_isolate,
			primary_flash0_isolate}, 8'h5);
		chk({secondary_host_reset_n, runtime_host_reset_n, fatal_error_n}, 8'h7);
		chk({primary_auth_led, secondary_auth_led}, 8'h3);
		chk({host_alert_oe, host_alert_out, target_address_sel}, 8'h5);
		chk({shared_flash_port_oe, flash_drive_oe, boot_progress_led_n}, 8'h2);
		$display("test boot done");
	endtask : t_boot
	task t_sec_mon;
		logic seen;
		int   i;
		seen = 1'h0;
		sec_mon_n = 1'h0;
		for (i = 0; i < 6; i++) begin
			cyc(1);
			seen = seen | events.secondary_unexpected;
		end
		sec_mon_n = 1'h1;
		chk({7'h0, seen}, 8'h1);
		chk({7'h0, secondary_host_reset_n}, 8'h1);
		$display("test secondary monitor done");
	endtask : t_sec_mon
	task t_ext;
		external_reset_in_n = 1'h0;
		await_lvl(1'b1, 1'h0);
		chk({6'h0, auth_primary_only, auth_start}, 8'h3);
		external_reset_in_n = 1'h1;
		grant(1'h1, 4'hf);
		await_lvl(1'b1, 1'h1);
		auth_result.done = 1'h0;
		$display("test external reset done");
	endtask : t_ext
	task t_watchdog;
		host_watchdog_reset_a = 1'h1;
		await_lvl(1'b0, 1'h0);
		host_watchdog_reset_a = 1'h0;
		release_host();
		auth_bypass = 1'h1;
		host_watchdog_reset_b = 1'h1;
		await_lvl(1'b0, 1'h0);
		await_lvl(1'b0, 1'h1);
		auth_bypass = 1'h0;
		host_watchdog_reset_b = 1'h0;
		$display("test watchdog done");
	endtask : t_watchdog
	task t_host_faults;
		cyc(40);
		chk({7'h0, primary_host_reset_n}, 8'h1);
		hb_stop = 1'h1;
		await_lvl(1'b0, 1'h0);
		hb_stop = 1'h0;
		release_host();
		cyc(5);
		crash = 1'h1;
		await_lvl(1'b0, 1'h0);
		crash = 1'h0;
		release_host();
		$display("test host faults done");
	endtask : t_host_faults
	task t_fatal;
		system_reset_detect_n = 1'h0;
		await_lvl(1'b0, 1'h0);
		system_reset_detect_n = 1'h1;
		grant(1'h0, 4'h0);
		cyc(4);
		chk({boot_progress_led_n, fatal_error_n, remote_access, runtime_host_reset_n, primary_flash1_isolate,
			primary_flash0_isolate}, 8'h0b);
		auth_result = '0;
		system_reset_detect_n = 1'h0;
		cyc(6);
		system_reset_detect_n = 1'h1;
		release_host();
		chk({fatal_error_n, remote_access}, 8'h2);
		$display("test fatal done");
	endtask : t_fatal
	task t_cfg_off;
		rst_n = 1'h0;
		cfg_on = 1'h0;
		auth_bypass = 1'h1;
		cyc(2);
		rst_n = 1'h1;
		cyc(12);
		chk({primary_host_reset_n, host_alert_oe, secondary_flash1_isolate,
			secondary_flash0_isolate}, 8'h3);
		auth_bypass = 1'h0;
		release_host();
		cyc(3);
		chk({secondary_host_reset_n, secondary_flash1_isolate, secondary_flash0_isolate,
			primary_flash1_isolate, primary_flash0_isolate}, 8'h0c);
		system_reset_detect_n = 1'h0;
		host_watchdog_reset_a = 1'h1;
		cyc(6);
		system_reset_detect_n = 1'h1;
		host_watchdog_reset_a = 1'h0;
		chk({7'h0, primary_host_reset_n}, 8'h1);
		$display("test config off done");
	endtask : t_cfg_off
	initial begin
		cyc(4);
		rst_n = 1'h1;
		t_boot();
		t_sec_mon();
		t_ext();
		t_watchdog();
		t_host_faults();
		t_fatal();
		t_cfg_off();
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
